// >>> test/tsd_rom_model.sv
// Program ROM as seen by the core: word derived from the lookup address
module tsd_rom_model (
    // Lookup from the block
    input wire logic [14:0] romAddr,
    input wire logic busy,
    // Word back to the block
    output logic [15:0] romData
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] romWord;

    // Word only valid while a lookup is in flight, inverted otherwise
    assign romWord = {8'h96 ^ {1'b0, romAddr[14:8]}, 8'hc3 ^ romAddr[7:0]};
    assign romData = busy ? romWord : ~romWord;
endmodule // tsd_rom_model

// >>> test/tsd_table_stack_mem_tb_top.sv
// Self-checking bench for the table, stack and data memory block
module tsd_table_stack_mem_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk;
    logic rst;
    logic cmdValid;
    tsd_pkg::tsd_cmd_t cmd;
    logic [14:0] pcIn;
    logic busy;
    logic done;
    logic [7:0] rdData;
    logic [14:0] romAddr;
    logic [15:0] romData;
    logic popValid;
    logic [14:0] popPc;
    logic pclLoad;
    logic [7:0] pclValue;
    logic stackFull;
    logic irqReq;
    logic irqTake;
    logic [7:0] lastRd;
    logic lastPop;
    logic lastPcl;
    int numErrors;
    int cmpCount;

    // Device and far-side ROM
    tsd_table_stack_mem i_dut (.core_clk(core_clk), .rst(rst), .cmdValid(cmdValid), .cmd(cmd), .pcIn(pcIn),
        .busy(busy), .done(done), .rdData(rdData), .romAddr(romAddr), .romData(romData), .popValid(popValid),
        .popPc(popPc), .pclLoad(pclLoad), .pclValue(pclValue), .stackFull(stackFull), .irqReq(irqReq),
        .irqTake(irqTake));
    tsd_rom_model i_rom (.romAddr(romAddr), .busy(busy), .romData(romData));

    // Clock source
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic giveVerdict();
        if (numErrors == 0 && cmpCount > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        cmpCount++;
        if (got !== exp)
        begin
            numErrors++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One request, held one cycle, then bounded wait for done
    task automatic run(input tsd_pkg::tsd_op_t o, input logic [7:0] a, input logic [7:0] d,
        input logic [2:0] b, input int expLat);
        int lat;
        @(negedge core_clk);
        cmdValid = 1'b1;
        cmd = '{op: o, addr: a, data: d, bitSel: b};
        @(negedge core_clk);
        cmdValid = 1'b0;
        lat = 1;
        if (expLat == 2)
            chk("busy", 16'h0001, {15'h0, busy});
        while (done !== 1'b1 && lat < 6)
        begin
            @(negedge core_clk);
            lat++;
        end
        if (done !== 1'b1)
        begin
            numErrors++;
            giveVerdict();
        end
        chk("latency", expLat[15:0], lat[15:0]);
        lastRd = rdData;
        lastPop = popValid;
        lastPcl = pclLoad;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        run(tsd_pkg::OP_WRITE, a, d, 3'h0, 1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        run(tsd_pkg::OP_READ, a, 8'h00, 3'h0, 1);
        chk("read data", {8'h00, exp}, {8'h00, lastRd});
    endtask

    // Modify location 70 in place and compare the written-back result
    task automatic modify(input tsd_pkg::tsd_op_t o, input logic [7:0] exp);
        run(o, 8'h70, 8'h00, 3'h0, 1);
        chk("modify result", {8'h00, exp}, {8'h00, lastRd});
    endtask

    task automatic testReset();
        chk("stack full", 16'h0000, {15'h0, stackFull});
        rd(tsd_pkg::OFF_BANK_SELECT, 8'h00);
        rd(tsd_pkg::OFF_TABLE_ADDR_LOW, 8'h00);
    endtask

    task automatic testTable();
        wr(tsd_pkg::OFF_TABLE_ADDR_HIGH, 8'h85);
        wr(tsd_pkg::OFF_TABLE_ADDR_LOW, 8'h5a);
        rd(tsd_pkg::OFF_TABLE_ADDR_HIGH, 8'h85);
        // Interrupt request stays low around the lookup
        run(tsd_pkg::OP_TBL_ANY, 8'h50, 8'h00, 3'h0, 2);
        chk("rom addr", 16'h053c + 16'h001e, {1'b0, romAddr});
        chk("low byte", 16'h0099, {8'h00, lastRd});
        rd(8'h50, 8'h99);
        rd(tsd_pkg::OFF_TABLE_RESULT_HIGH, 8'h93);
        wr(tsd_pkg::OFF_TABLE_ADDR_LOW, 8'h0f);
        run(tsd_pkg::OP_TBL_LAST, 8'h51, 8'h00, 3'h0, 2);
        chk("rom addr", 16'h7f0f, {1'b0, romAddr});
        rd(tsd_pkg::OFF_TABLE_RESULT_HIGH, 8'he9);
        wr(tsd_pkg::OFF_TABLE_RESULT_HIGH, 8'h00);
        rd(tsd_pkg::OFF_TABLE_RESULT_HIGH, 8'he9);
    endtask

    task automatic testIndirect();
        wr(tsd_pkg::OFF_POINTER_ZERO, 8'h60);
        wr(tsd_pkg::OFF_INDIRECT_PORT_ZERO, 8'ha5);
        rd(8'h60, 8'ha5);
        wr(tsd_pkg::OFF_BANK_SELECT, 8'h03);
        wr(tsd_pkg::OFF_POINTER_ONE, 8'h60);
        wr(tsd_pkg::OFF_INDIRECT_PORT_ONE, 8'h5e);
        rd(tsd_pkg::OFF_INDIRECT_PORT_ONE, 8'h5e);
        rd(tsd_pkg::OFF_INDIRECT_PORT_ZERO, 8'ha5);
        rd(8'h60, 8'ha5);
        wr(tsd_pkg::OFF_BANK_SELECT, 8'h0c);
        wr(tsd_pkg::OFF_INDIRECT_PORT_ONE, 8'h77);
        rd(tsd_pkg::OFF_INDIRECT_PORT_ONE, 8'h00);
        wr(tsd_pkg::OFF_BANK_SELECT, 8'h00);
        wr(8'h0f, 8'h44);
        rd(8'h0f, 8'h00);
        wr(8'hff, 8'h3c);
        rd(8'hff, 8'h3c);
    endtask

    task automatic testAlu();
        wr(tsd_pkg::OFF_ACCUMULATOR, 8'h11);
        wr(8'h70, 8'h22);
        run(tsd_pkg::OP_ADD, 8'h70, 8'h00, 3'h0, 1);
        chk("add", 16'h0033, {8'h00, lastRd});
        run(tsd_pkg::OP_INC, 8'h70, 8'h00, 3'h0, 1);
        rd(8'h70, 8'h34);
        run(tsd_pkg::OP_BIT_SET, 8'h70, 8'h00, 3'h3, 1);
        run(tsd_pkg::OP_BIT_CLEAR, 8'h70, 8'h00, 3'h2, 1);
        rd(8'h70, 8'h38);
        modify(tsd_pkg::OP_XOR, 8'h29);
        modify(tsd_pkg::OP_AND, 8'h01);
        modify(tsd_pkg::OP_OR, 8'h11);
        modify(tsd_pkg::OP_ROTR, 8'h88);
        modify(tsd_pkg::OP_ROTL, 8'h11);
        modify(tsd_pkg::OP_DEC, 8'h10);
        rd(8'h70, 8'h10);
        run(tsd_pkg::OP_BIT_SET, tsd_pkg::OFF_CORE_FLAGS, 8'h00, 3'h4, 1);
        rd(tsd_pkg::OFF_CORE_FLAGS, 8'h00);
        wr(tsd_pkg::OFF_CORE_FLAGS, 8'h3f);
        run(tsd_pkg::OP_BIT_CLEAR, tsd_pkg::OFF_CORE_FLAGS, 8'h00, 3'h5, 1);
        run(tsd_pkg::OP_BIT_CLEAR, tsd_pkg::OFF_CORE_FLAGS, 8'h00, 3'h0, 1);
        rd(tsd_pkg::OFF_CORE_FLAGS, 8'h3e);
    endtask

    task automatic testPcl();
        pcIn = 15'h2b7e;
        wr(tsd_pkg::OFF_PROGRAM_COUNTER_LOW, 8'hc4);
        chk("pcl load", 16'h01c4, {7'h0, lastPcl, pclValue});
        rd(tsd_pkg::OFF_PROGRAM_COUNTER_LOW, 8'h7e);
    endtask

    task automatic testStack();
        int n;
        for (int i = 1; i <= 9; i++)
        begin
            pcIn = 15'(i);
            run(tsd_pkg::OP_CALL, 8'h00, 8'h00, 3'h0, 1);
        end
        chk("stack full", 16'h0001, {15'h0, stackFull});
        // Request while full: flag kept, no acknowledge
        @(negedge core_clk);
        irqReq = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            @(negedge core_clk);
            irqReq = 1'b0;
            chk("irq take", 16'h0000, {15'h0, irqTake});
        end
        pcIn = 15'h0100;
        run(tsd_pkg::OP_ROUTINE_EXIT, 8'h00, 8'h00, 3'h0, 1);
        chk("pop", 16'h8009, {lastPop, popPc});
        n = 0;
        while (irqTake !== 1'b1 && n < 5)
        begin
            @(negedge core_clk);
            n++;
        end
        chk("irq taken", 16'h0001, {15'h0, irqTake});
        if (irqTake !== 1'b1)
            giveVerdict();
        for (int j = 0; j < 8; j++)
        begin
            run(tsd_pkg::OP_INTERRUPT_EXIT, 8'h00, 8'h00, 3'h0, 1);
            chk("pop", (j == 0) ? 16'h8100 : 16'h8000 + 16'(9 - j), {lastPop, popPc});
        end
    endtask

    // Call and exit on consecutive cycles
    task automatic testCallPair();
        @(negedge core_clk);
        pcIn = 15'h4321;
        cmdValid = 1'b1;
        cmd = '{op: tsd_pkg::OP_CALL, addr: 8'h00, data: 8'h00, bitSel: 3'h0};
        @(negedge core_clk);
        chk("call done", 16'h0001, {15'h0, done});
        pcIn = 15'h0000;
        cmd.op = tsd_pkg::OP_ROUTINE_EXIT;
        @(negedge core_clk);
        cmdValid = 1'b0;
        chk("pop", 16'hc321, {popValid, popPc});
    endtask

    // Reset in mid-run with entries on the stack
    task automatic testMidReset();
        for (int i = 0; i < 3; i++)
        begin
            run(tsd_pkg::OP_CALL, 8'h00, 8'h00, 3'h0, 1);
        end
        @(negedge core_clk);
        rst = 1'b1;
        repeat (2) @(negedge core_clk);
        rst = 1'b0;
        chk("stack full", 16'h0000, {15'h0, stackFull});
        for (int i = 0; i < 7; i++)
        begin
            run(tsd_pkg::OP_CALL, 8'h00, 8'h00, 3'h0, 1);
        end
        chk("stack full", 16'h0000, {15'h0, stackFull});
        pcIn = 15'h1234;
        run(tsd_pkg::OP_CALL, 8'h00, 8'h00, 3'h0, 1);
        chk("stack full", 16'h0001, {15'h0, stackFull});
        run(tsd_pkg::OP_ROUTINE_EXIT, 8'h00, 8'h00, 3'h0, 1);
        chk("pop", 16'h9234, {lastPop, popPc});
    endtask

    // Main sequence
    initial
    begin
        numErrors = 0;
        cmpCount = 0;
        rst = 1'b1;
        cmdValid = 1'b0;
        cmd = '0;
        pcIn = 15'h0000;
        irqReq = 1'b0;
        repeat (6) @(negedge core_clk);
        rst = 1'b0;
        testReset();
        testTable();
        testIndirect();
        testAlu();
        testPcl();
        testStack();
        testCallPair();
        testMidReset();
        giveVerdict();
    end
endmodule // tsd_table_stack_mem_tb_top

// >>> verilog/tsd_pkg.sv
// Constants, operation codes and carrier types for the table/stack/data memory block
package tsd_pkg;

    // Data memory register offsets
    localparam logic [7:0] OFF_INDIRECT_PORT_ZERO = 8'h00;
    localparam logic [7:0] OFF_POINTER_ZERO = 8'h01;
    localparam logic [7:0] OFF_INDIRECT_PORT_ONE = 8'h02;
    localparam logic [7:0] OFF_POINTER_ONE = 8'h03;
    localparam logic [7:0] OFF_BANK_SELECT = 8'h04;
    localparam logic [7:0] OFF_ACCUMULATOR = 8'h05;
    localparam logic [7:0] OFF_PROGRAM_COUNTER_LOW = 8'h06;
    localparam logic [7:0] OFF_TABLE_ADDR_LOW = 8'h07;
    localparam logic [7:0] OFF_TABLE_RESULT_HIGH = 8'h08;
    localparam logic [7:0] OFF_WATCHDOG_OPTIONS = 8'h09;
    localparam logic [7:0] OFF_CORE_FLAGS = 8'h0a;
    localparam logic [7:0] OFF_IRQ_CONTROL_ZERO = 8'h0b;
    localparam logic [7:0] OFF_COUNTER0_HIGH = 8'h0c;
    localparam logic [7:0] OFF_COUNTER0_LOW = 8'h0d;
    localparam logic [7:0] OFF_COUNTER0_CONTROL = 8'h0e;
    localparam logic [7:0] OFF_PORT_A_DATA = 8'h12;
    localparam logic [7:0] OFF_PORT_A_DIRECTION = 8'h13;
    localparam logic [7:0] OFF_PORT_B_DATA = 8'h14;
    localparam logic [7:0] OFF_PORT_B_DIRECTION = 8'h15;
    localparam logic [7:0] OFF_IRQ_CONTROL_ONE = 8'h1e;
    localparam logic [7:0] OFF_TABLE_ADDR_HIGH = 8'h1f;
    localparam logic [7:0] OFF_CLOCK_CALENDAR_CONTROL = 8'h24;
    localparam logic [7:0] OFF_CLOCK_MODE_CONTROL = 8'h26;
    localparam logic [7:0] OFF_COUNTER2_HIGH = 8'h2a;
    localparam logic [7:0] OFF_COUNTER2_LOW = 8'h2b;
    localparam logic [7:0] OFF_COUNTER2_CONTROL = 8'h2c;
    localparam logic [7:0] OFF_DISPLAY_CONTROL = 8'h2d;
    localparam logic [7:0] OFF_FREQ_DIVIDER_CONTROL = 8'h2f;
    localparam logic [7:0] OFF_PULSE_DAC_CONTROL = 8'h30;
    localparam logic [7:0] OFF_PULSE_DAC_VALUE = 8'h31;
    localparam logic [7:0] OFF_SERIAL_CONTROL = 8'h32;
    localparam logic [7:0] OFF_SERIAL_DATA = 8'h33;
    localparam logic [7:0] OFF_DISPLAY_DRIVE_LEVEL = 8'h34;
    localparam logic [7:0] OFF_PORT_A_PULLUP = 8'h35;
    localparam logic [7:0] OFF_PORT_B_PULLUP = 8'h36;
    localparam logic [7:0] OFF_SEGMENT_PORT0_DATA = 8'h37;
    localparam logic [7:0] OFF_SEGMENT_PORT0_DIRECTION = 8'h38;
    localparam logic [7:0] OFF_SEGMENT_PORT1_DATA = 8'h39;
    localparam logic [7:0] OFF_SEGMENT_PORT1_DIRECTION = 8'h3a;

    // One bit per implemented special register offset 00..3f
    localparam logic [63:0] SFR_IMPL_MASK = 64'h07ff_bc50_c03c_7fff;

    // Memory organisation
    localparam logic [7:0] GP_BASE = 8'h40;
    localparam logic [4:0] GP_BANKS = 5'h0c;
    localparam logic [11:0] BANK_BYTES = 12'h0c0;
    localparam int GP_BYTES = 2304;
    localparam int SFR_COUNT = 64;

    // Table read, stack, protected flag and reset constants
    localparam logic [6:0] LAST_PAGE = 7'h7f;
    localparam logic [3:0] STACK_DEPTH = 4'h8;
    localparam logic [7:0] FLAGS_PROTECTED = 8'h30;
    localparam logic [7:0] SFR_RESET = 8'h00;

    // Operations issued by the core
    typedef enum logic [4:0] {
        OP_NOP = 5'h00,
        OP_READ = 5'h01,
        OP_WRITE = 5'h02,
        OP_INC = 5'h03,
        OP_DEC = 5'h04,
        OP_ROTL = 5'h05,
        OP_ROTR = 5'h06,
        OP_ADD = 5'h07,
        OP_AND = 5'h08,
        OP_OR = 5'h09,
        OP_XOR = 5'h0a,
        OP_BIT_SET = 5'h0b,
        OP_BIT_CLEAR = 5'h0c,
        OP_TBL_ANY = 5'h0d,
        OP_TBL_LAST = 5'h0e,
        OP_CALL = 5'h0f,
        OP_ROUTINE_EXIT = 5'h10,
        OP_INTERRUPT_EXIT = 5'h11
    } tsd_op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h1,
        ST_TABLE = 2'h2
    } tsd_state_t;

    typedef struct packed {
        tsd_op_t op;
        logic [7:0] addr;
        logic [7:0] data;
        logic [2:0] bitSel;
    } tsd_cmd_t;

endpackage

// >>> verilog/tsd_table_stack_mem.sv
// Table read, return stack and data memory logic beside the processor core
// Operation
// R01: Table read: low byte to [m], high to result
// R02: Table result high register is read-only
// R03: Table pointer is two read/write registers
// R04: Any-bank address from pointer high and low
// R05: Last-page read forces upper bits high
// R06: Table reads take two cycles
// R07: Software guards table reads against interrupts
// R08: Eight-level stack, not software visible
// R09: Call/interrupt push; exits pop
// R10: Stack index at top after reset
// R11: Full stack defers interrupt acknowledge
// R12: Call on full stack drops oldest
// R13: Twelve banks of 192 data bytes
// R14: Bank zero 00-3F decodes to registers
// R15: 40-FF is general-purpose storage
// R16: Arithmetic operates directly on memory
// R17: Bit set/clear, except protected bits
// R18: Indirect ports at 00 and 02
// R19: Pointers at 01 and 03
// R20: Program counter low byte at 06
// R21: Banks 1-11 only via second pointer
// R22: Indirect port accesses pointed location
// R23: Any-bank read ignores program bank
module tsd_table_stack_mem (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Operation request from the core
    input wire logic cmdValid,
    input wire tsd_pkg::tsd_cmd_t cmd,
    input wire logic [14:0] pcIn,
    output logic busy,
    output logic done,
    output logic [7:0] rdData,
    // Program ROM lookup
    output logic [14:0] romAddr,
    input wire logic [15:0] romData,
    // Stack and program counter
    output logic popValid,
    output logic [14:0] popPc,
    output logic pclLoad,
    output logic [7:0] pclValue,
    output logic stackFull,
    // Interrupt request and acknowledge
    input wire logic irqReq,
    output logic irqTake
);

    tsd_pkg::tsd_state_t state;
    tsd_pkg::tsd_state_t next_state;
    logic [7:0] sfr [tsd_pkg::SFR_COUNT];
    logic [7:0] gp [tsd_pkg::GP_BYTES];
    logic [14:0] stk [8];
    logic [2:0] stkPtr;
    logic [3:0] stkCnt;
    logic [7:0] tblDest;
    logic irqFlag;
    logic [7:0] next_val;
    logic wrReq;

    // Request decode
    wire fire = cmdValid && (state == tsd_pkg::ST_IDLE);
    wire inTable = (state == tsd_pkg::ST_TABLE);
    wire opTbl = (cmd.op == tsd_pkg::OP_TBL_ANY) || (cmd.op == tsd_pkg::OP_TBL_LAST);
    wire opCall = (cmd.op == tsd_pkg::OP_CALL);
    wire opExit = (cmd.op == tsd_pkg::OP_ROUTINE_EXIT) || (cmd.op == tsd_pkg::OP_INTERRUPT_EXIT);

    // Named special registers
    wire [7:0] ptr0 = sfr[tsd_pkg::OFF_POINTER_ZERO[5:0]];
    wire [7:0] ptr1 = sfr[tsd_pkg::OFF_POINTER_ONE[5:0]];
    wire [7:0] bankSel = sfr[tsd_pkg::OFF_BANK_SELECT[5:0]];
    wire [7:0] acc = sfr[tsd_pkg::OFF_ACCUMULATOR[5:0]];
    wire [7:0] table_addr_low = sfr[tsd_pkg::OFF_TABLE_ADDR_LOW[5:0]];
    wire [7:0] table_addr_high = sfr[tsd_pkg::OFF_TABLE_ADDR_HIGH[5:0]];
    wire [7:0] table_result_high = sfr[tsd_pkg::OFF_TABLE_RESULT_HIGH[5:0]];

    // Address resolution, direct or through a pointer
    wire [7:0] accAddr = inTable ? tblDest : cmd.addr;
    wire indZero = (accAddr == tsd_pkg::OFF_INDIRECT_PORT_ZERO); // R18
    wire indOne = (accAddr == tsd_pkg::OFF_INDIRECT_PORT_ONE); // R18
    wire [7:0] effAddr = indZero ? ptr0 : (indOne ? ptr1 : accAddr); // R22 R19
    wire [4:0] effBank = indOne ? bankSel[4:0] : 5'h00; // R21
    wire inSfr = (effBank == 5'h00) && (effAddr < tsd_pkg::GP_BASE); // R14
    wire inGp = (effAddr >= tsd_pkg::GP_BASE) && (effBank < tsd_pkg::GP_BANKS); // R15 R13
    wire [11:0] gpIdx = 12'(effBank) * tsd_pkg::BANK_BYTES + 12'(effAddr) - 12'(tsd_pkg::GP_BASE); // R13
    wire [5:0] sfrIdx = effAddr[5:0];
    wire isIar = (effAddr == tsd_pkg::OFF_INDIRECT_PORT_ZERO) || (effAddr == tsd_pkg::OFF_INDIRECT_PORT_ONE);
    wire isPcl = inSfr && (effAddr == tsd_pkg::OFF_PROGRAM_COUNTER_LOW);
    wire isTblh = (effAddr == tsd_pkg::OFF_TABLE_RESULT_HIGH);
    wire sfrLive = inSfr && tsd_pkg::SFR_IMPL_MASK[sfrIdx] && !isIar;
    wire sfrWritable = sfrLive && !isTblh && !isPcl; // R02

    // Value currently held at the resolved location
    wire [7:0] sfrVal = isPcl ? pcIn[7:0] : (sfrLive ? sfr[sfrIdx] : 8'h00); // R20
    wire [7:0] curVal = inSfr ? sfrVal : (inGp ? gp[gpIdx] : 8'h00);

    // Bit operation masks
    wire [7:0] bitMask = 8'h01 << cmd.bitSel;
    wire isFlags = inSfr && (effAddr == tsd_pkg::OFF_CORE_FLAGS);
    wire [7:0] protMask = isFlags ? tsd_pkg::FLAGS_PROTECTED : 8'h00;
    wire [7:0] bitKeep = bitMask & ~protMask; // R17

    // Table pointer to ROM address
    wire [14:0] anyAddr = {table_addr_high[6:0], table_addr_low}; // R04 R23 R03
    wire [14:0] lastAddr = {tsd_pkg::LAST_PAGE, table_addr_low}; // R05

    // Stack control
    wire isFull = (stkCnt == tsd_pkg::STACK_DEPTH);
    wire irqGo = irqFlag && !isFull && !inTable && !fire; // R11
    wire doPush = (fire && opCall) || irqGo; // R09
    wire doPop = fire && opExit; // R09
    wire [2:0] popPtr = stkPtr - 3'h1;
    wire [3:0] pushCnt = isFull ? stkCnt : stkCnt + 4'h1; // R12
    wire [3:0] popCnt = (stkCnt == 4'h0) ? stkCnt : stkCnt - 4'h1;

    // Result of the operation on the resolved location
    always_comb
    begin
        next_val = curVal;
        wrReq = 1'b0;
        next_state = state;
        if (inTable)
        begin
            next_val = romData[7:0]; // R01
            wrReq = 1'b1;
            next_state = tsd_pkg::ST_IDLE;
        end
        else if (fire)
        begin
            wrReq = 1'b1;
            unique case (cmd.op)
                tsd_pkg::OP_WRITE: next_val = cmd.data;
                tsd_pkg::OP_INC: next_val = curVal + 8'h01; // R16
                tsd_pkg::OP_DEC: next_val = curVal - 8'h01; // R16
                tsd_pkg::OP_ROTL: next_val = {curVal[6:0], curVal[7]}; // R16
                tsd_pkg::OP_ROTR: next_val = {curVal[0], curVal[7:1]}; // R16
                tsd_pkg::OP_ADD: next_val = curVal + acc; // R16
                tsd_pkg::OP_AND: next_val = curVal & acc; // R16
                tsd_pkg::OP_OR: next_val = curVal | acc; // R16
                tsd_pkg::OP_XOR: next_val = curVal ^ acc; // R16
                tsd_pkg::OP_BIT_SET: next_val = curVal | bitKeep; // R17
                tsd_pkg::OP_BIT_CLEAR: next_val = curVal & ~bitKeep; // R17
                tsd_pkg::OP_TBL_ANY, tsd_pkg::OP_TBL_LAST:
                begin
                    wrReq = 1'b0;
                    next_state = tsd_pkg::ST_TABLE; // R06
                end
                default: wrReq = 1'b0;
            endcase
        end
    end

    // Sequencing, handshake and ROM address
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            state <= tsd_pkg::ST_IDLE;
            busy <= 1'b0;
            done <= 1'b0;
            rdData <= 8'h00;
            romAddr <= 15'h0000;
            tblDest <= 8'h00;
            pclLoad <= 1'b0;
            pclValue <= 8'h00;
        end
        else
        begin
            state <= next_state;
            busy <= (next_state == tsd_pkg::ST_TABLE);
            done <= (fire && !opTbl) || inTable; // R06
            if ((fire && !opTbl) || inTable)
            begin
                rdData <= wrReq ? next_val : curVal;
            end
            if (fire && opTbl)
            begin
                romAddr <= (cmd.op == tsd_pkg::OP_TBL_ANY) ? anyAddr : lastAddr; // R04 R05
                tblDest <= cmd.addr;
            end
            pclLoad <= wrReq && isPcl;
            if (wrReq && isPcl)
            begin
                pclValue <= next_val;
            end
        end
    end

    // Special register file
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < tsd_pkg::SFR_COUNT; i++)
            begin
                sfr[i] <= tsd_pkg::SFR_RESET;
            end
        end
        else
        begin
            if (wrReq && sfrWritable)
            begin
                sfr[sfrIdx] <= next_val;
            end
            if (inTable)
            begin
                sfr[tsd_pkg::OFF_TABLE_RESULT_HIGH[5:0]] <= romData[15:8]; // R01 R02
            end
        end
    end

    // General-purpose banks, uninitialised storage
    always_ff @(posedge core_clk)
    begin
        if (wrReq && inGp)
        begin
            gp[gpIdx] <= next_val; // R15 R21
        end
    end

    // Interrupt request flag, a new request wins over the acknowledge
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            irqFlag <= 1'b0;
            irqTake <= 1'b0;
        end
        else
        begin
            irqFlag <= irqReq || (irqFlag && !irqGo); // R11
            irqTake <= irqGo; // R11
        end
    end

    // Return addresses, no reset: the index says what is valid
    always_ff @(posedge core_clk)
    begin
        if (!rst && doPush)
        begin
            stk[stkPtr] <= pcIn; // R09 R08
        end
    end

    // Stack index and depth, a push on a full ring drops the oldest
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            stkPtr <= 3'h0; // R10
            stkCnt <= 4'h0; // R10
            stackFull <= 1'b0;
        end
        else if (doPush)
        begin
            stkPtr <= stkPtr + 3'h1; // R12
            stkCnt <= pushCnt; // R12
            stackFull <= (pushCnt == tsd_pkg::STACK_DEPTH); // R11
        end
        else if (doPop)
        begin
            stkPtr <= popPtr;
            stkCnt <= popCnt;
            stackFull <= 1'b0;
        end
    end

    // Popped address and its strobe for the core
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            popValid <= 1'b0;
            popPc <= 15'h0000;
        end
        else
        begin
            popValid <= doPop;
            if (doPop)
            begin
                popPc <= stk[popPtr]; // R09
            end
        end
    end

    // Checks on the design's own behaviour
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    chk_tbl_two_cycle: assert property ( // R06
        fire && opTbl |=> busy ##1 (done && !busy))
        else $error("table read did not finish in two cycles");

    chk_tbl_any_addr: assert property ( // R04
        fire && cmd.op == tsd_pkg::OP_TBL_ANY |=> romAddr == {$past(table_addr_high[6:0]), $past(table_addr_low)})
        else $error("any-bank table address wrong");

    chk_tbl_last_addr: assert property ( // R05
        fire && cmd.op == tsd_pkg::OP_TBL_LAST |=> romAddr[14:8] == tsd_pkg::LAST_PAGE
            && romAddr[7:0] == $past(table_addr_low))
        else $error("last-page table address wrong");

    chk_table_result_high_load: assert property ( // R01
        inTable |=> table_result_high == $past(romData[15:8]) && rdData == $past(romData[7:0]))
        else $error("table result bytes not stored");

    chk_table_result_high_readonly: assert property ( // R02
        fire && !opTbl |=> $stable(table_result_high))
        else $error("table result high changed without table read");

    chk_irq_defer: assert property ( // R11
        irqFlag && stackFull |=> !irqTake)
        else $error("interrupt taken with full stack");

    chk_irq_serve: assert property ( // R11
        irqFlag && !stackFull && !busy && !cmdValid |=> irqTake)
        else $error("pending interrupt not taken");

    chk_overflow_keep: assert property ( // R12
        fire && opCall && stackFull |=> stackFull)
        else $error("call on full stack changed depth");

    chk_call_pair: assert property ( // R09
        (fire && opCall) ##1 (fire && cmd.op == tsd_pkg::OP_ROUTINE_EXIT)
            |=> popValid && popPc == $past(pcIn, 2))
        else $error("pop did not return pushed address");

    chk_pcl_read: assert property ( // R20
        fire && cmd.op == tsd_pkg::OP_READ && cmd.addr == tsd_pkg::OFF_PROGRAM_COUNTER_LOW
            |=> done && rdData == $past(pcIn[7:0]))
        else $error("program counter low byte not read");

    chk_flag_protect: assert property ( // R17
        fire && (cmd.op == tsd_pkg::OP_BIT_SET || cmd.op == tsd_pkg::OP_BIT_CLEAR)
            && cmd.addr == tsd_pkg::OFF_CORE_FLAGS
            && tsd_pkg::FLAGS_PROTECTED[cmd.bitSel]
            |=> $stable(sfr[tsd_pkg::OFF_CORE_FLAGS[5:0]]))
        else $error("protected flag bit cleared");

    // Stack, memory map and core handoff checks

    chk_reset_top: assert property ( // R10
        $fell(rst) |-> stkPtr == 3'h0 && stkCnt == 4'h0 && !stackFull)
        else $error("stack index not at top after reset");

    chk_push_store: assert property ( // R09
        doPush |=> stk[$past(stkPtr)] == $past(pcIn))
        else $error("pushed address not stored");

    chk_pop_strobe: assert property ( // R09
        fire && opExit |=> popValid && done && !irqTake)
        else $error("exit did not pop");

    chk_gp_write: assert property ( // R15
        fire && cmd.op == tsd_pkg::OP_WRITE && cmd.addr >= tsd_pkg::GP_BASE
            |=> gp[$past(cmd.addr) - tsd_pkg::GP_BASE] == $past(cmd.data))
        else $error("general-purpose write lost");

    chk_tptr_read: assert property ( // R03
        fire && cmd.op == tsd_pkg::OP_READ && cmd.addr == tsd_pkg::OFF_TABLE_ADDR_HIGH
            |=> done && rdData == $past(table_addr_high))
        else $error("table pointer high not readable");

    chk_pcl_load: assert property ( // R20
        fire && cmd.op == tsd_pkg::OP_WRITE && cmd.addr == tsd_pkg::OFF_PROGRAM_COUNTER_LOW
            |=> pclLoad && pclValue == $past(cmd.data))
        else $error("program counter low write not passed on");

    cov_tbl_any: cover property (fire && cmd.op == tsd_pkg::OP_TBL_ANY ##2 done);
    cov_irq_deferred: cover property (irqFlag && stackFull ##[1:20] irqTake);
    cov_overflow: cover property (fire && opCall && stackFull);
    cov_call_exit: cover property ((fire && opCall) ##1 (fire && opExit));
    cov_tbl_last: cover property (fire && cmd.op == tsd_pkg::OP_TBL_LAST ##2 done);

endmodule // tsd_table_stack_mem
